// file: pkg/pdio_map.svh
// Register map, field positions, reset values and timing counts of the digital I/O port
`ifndef PDIO_MAP_SVH
`define PDIO_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define PDIO_IDX_BYTE_LOW   10'h088
`define PDIO_IDX_BYTE_HIGH  10'h089
`define PDIO_ADDR_BYTE_LOW  ({`PDIO_IDX_BYTE_LOW, 2'b00})
`define PDIO_ADDR_BYTE_HIGH ({`PDIO_IDX_BYTE_HIGH, 2'b00})
`define PDIO_ADDR_RISE_EN   12'h300
`define PDIO_ADDR_FALL_EN   12'h304
`define PDIO_ADDR_DELAY_CFG 12'h308
`define PDIO_ADDR_PENDING   12'h30C
`define PDIO_ADDR_DIAG      12'h310
`define PDIO_ADDR_OUT_SEL   12'h314
`define PDIO_ADDR_W         12

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define PDIO_OUT_BYTE_POS   8
`define PDIO_DIAG_LOST_BIT  0
`define PDIO_GROUP_SIZE     4
`define PDIO_FAST_MASK      16'h8EDB
`define PDIO_CNT_W          19

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PDIO_OUT_LOW_RST    8'h00
`define PDIO_OUT_HIGH_RST   4'h0
`define PDIO_EDGE_EN_RST    16'h0000
`define PDIO_DELAY_CFG_RST  8'hAA
`define PDIO_OUT_SEL_RST    8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PDIO_CLK_MHZ        25
`define PDIO_DLY_100US_NS   100000
`define PDIO_DLY_500US_NS   500000
`define PDIO_DLY_3MS_NS     3000000
`define PDIO_DLY_15MS_NS    15000000
`define PDIO_NS_TO_CYC(ns)  ((((ns) * `PDIO_CLK_MHZ) + 999) / 1000)
`define PDIO_DLY_100US_CYC  `PDIO_NS_TO_CYC(`PDIO_DLY_100US_NS)
`define PDIO_DLY_500US_CYC  `PDIO_NS_TO_CYC(`PDIO_DLY_500US_NS)
`define PDIO_DLY_3MS_CYC    `PDIO_NS_TO_CYC(`PDIO_DLY_3MS_NS)
`define PDIO_DLY_15MS_CYC   `PDIO_NS_TO_CYC(`PDIO_DLY_15MS_NS)

`endif

// file: pkg/pdio_pkg.sv
// Types shared by the digital I/O port modules
package pdio_pkg;

  // Input delay choice of one group of four inputs
  typedef enum logic [1:0] {
    PDIO_DLY_100US,
    PDIO_DLY_500US,
    PDIO_DLY_3MS,
    PDIO_DLY_15MS
  } pdio_delay_type;

  // Source of a shared output pin
  typedef enum logic [1:0] {
    PDIO_SRC_PLAIN,
    PDIO_SRC_PWM,
    PDIO_SRC_COUNTER,
    PDIO_SRC_SPARE
  } pdio_src_type;

  typedef logic [31:0] pdio_word_type;

endpackage : pdio_pkg

// file: pkg/pdio_filt_if.sv
// Interface between the port core and one input delay filter
`timescale 1ns/1ps
`include "pdio_map.svh"

interface pdio_filt_if;
  logic                   raw;
  logic [`PDIO_CNT_W-1:0] limit;
  logic                   level;

  modport filt (input raw, input limit, output level);
  modport ctrl (output raw, output limit, input level);
endinterface : pdio_filt_if

// file: hdl/pdio_in_filter.sv
// Input delay filter for one digital input channel
`timescale 1ns/1ps
`include "pdio_map.svh"

module pdio_in_filter (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  pdio_filt_if.filt flt
);
  import pdio_pkg::*;

  logic [`PDIO_CNT_W-1:0] hold_cnt_reg;
  logic                   level_reg;

  // Level follows the raw input only after it held for limit cycles
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      hold_cnt_reg <= '0;
      level_reg    <= 1'b0;
    end else if (ce_i) begin
      if (flt.raw == level_reg) begin
        hold_cnt_reg <= '0;
      end else if (hold_cnt_reg >= flt.limit - `PDIO_CNT_W'(1)) begin
        level_reg    <= flt.raw;
        hold_cnt_reg <= '0;
      end else begin
        hold_cnt_reg <= hold_cnt_reg + `PDIO_CNT_W'(1);
      end
    end
  end

  assign flt.level = level_reg;

endmodule : pdio_in_filter

// file: hdl/pdio_port.sv
// Onboard digital I/O port: filtered inputs, edge events, outputs and indicators
//
// Notes on behaviour
// - First input connector is input byte 136
// - Second input connector is input byte 137
// - Edge event enable per input, per direction
// - All edge event enables reset to disabled
// - Rising 0-1, falling 1-0 on filtered level
// - Only diagnostic event is event lost
// - One delay setting per four adjacent inputs
// - Delay choices 0.1, 0.5, 3, 15 ms
// - Shortest delay only on fast inputs
// - Slow inputs use 0.5 ms instead
// - Fast inputs 100 kHz, others 1 kHz
// - Output byte 136 drives outputs 0 to 7
// - Output byte 137 drives outputs 8 to 11
// - Green indicator shows each input level
// - Green indicator shows each output level
// - Red indicator on output overload
// - Outputs 0,1: plain, PWM or counter
// - Outputs 2,3: plain or counter
// - Inputs feed counter A and B tracks
// - Input 11 gate, input 15 latch
`timescale 1ns/1ps
`include "pdio_map.svh"

module pdio_port #(
  parameter int unsigned DLY_500US_CYC = `PDIO_DLY_500US_CYC,
  parameter int unsigned DLY_3MS_CYC   = `PDIO_DLY_3MS_CYC,
  parameter int unsigned DLY_15MS_CYC  = `PDIO_DLY_15MS_CYC
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_i,
  input  wire logic                         ce_i,
  // AXI4-Lite slave
  input  wire logic [`PDIO_ADDR_W-1:0]      axi_awaddr_i,
  input  wire logic                         axi_awvalid_i,
  output logic                              axi_awready_o,
  input  wire pdio_pkg::pdio_word_type      axi_wdata_i,
  input  wire logic [3:0]                   axi_wstrb_i,
  input  wire logic                         axi_wvalid_i,
  output logic                              axi_wready_o,
  output logic [1:0]                        axi_bresp_o,
  output logic                              axi_bvalid_o,
  input  wire logic                         axi_bready_i,
  input  wire logic [`PDIO_ADDR_W-1:0]      axi_araddr_i,
  input  wire logic                         axi_arvalid_i,
  output logic                              axi_arready_o,
  output pdio_pkg::pdio_word_type           axi_rdata_o,
  output logic [1:0]                        axi_rresp_o,
  output logic                              axi_rvalid_o,
  input  wire logic                         axi_rready_i,
  // Field side
  input  wire logic [15:0]                  din_i,
  output logic [11:0]                       dout_o,
  input  wire logic                         overload_i,
  input  wire logic [1:0]                   pwm_i,
  input  wire logic [3:0]                   cnt_out_i,
  // Counter feeds
  output logic [3:0]                        cnt_a_o,
  output logic [3:0]                        cnt_b_o,
  output logic                              gate3_o,
  output logic                              latch3_o,
  // Events and indicators
  output logic                              hw_event_o,
  output logic                              diag_event_o,
  output logic [15:0]                       in_led_o,
  output logic [11:0]                       out_led_o,
  output logic                              err_led_o
);
  import pdio_pkg::*;

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [`PDIO_CNT_W-1:0] LIM_100US = `PDIO_CNT_W'(`PDIO_DLY_100US_CYC);
  localparam logic [`PDIO_CNT_W-1:0] LIM_500US = `PDIO_CNT_W'(DLY_500US_CYC);
  localparam logic [`PDIO_CNT_W-1:0] LIM_3MS   = `PDIO_CNT_W'(DLY_3MS_CYC);
  localparam logic [`PDIO_CNT_W-1:0] LIM_15MS  = `PDIO_CNT_W'(DLY_15MS_CYC);
  localparam logic [15:0]            FAST_MASK = `PDIO_FAST_MASK;      // Inputs rated for the fast rate

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [`PDIO_ADDR_W-1:0] aw_addr_reg;
  logic                    aw_full_reg;
  pdio_word_type           w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    w_full_reg;
  logic                    awready_reg;
  logic                    wready_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    arready_reg;
  logic                    rvalid_reg;
  pdio_word_type           rdata_reg;
  logic [1:0]              rresp_reg;
  logic                    do_write;
  logic                    wr_hit;
  logic                    rd_hit;
  pdio_word_type           rd_word;

  logic [7:0]              out_low_reg;
  logic [3:0]              out_high_reg;
  logic [15:0]             rise_en_reg;
  logic [15:0]             fall_en_reg;
  pdio_delay_type          delay_cfg_reg [4];
  pdio_src_type            out_sel_reg [4];
  logic [15:0]             pend_reg;
  logic                    lost_reg;
  logic [15:0]             pend_clr;
  logic                    lost_clr;

  logic [15:0]             filt_lvl;
  logic [15:0]             prev_lvl_reg;
  logic [15:0]             edge_evt;
  logic [11:0]             dout_next;

  logic [11:0]             dout_reg;
  logic [11:0]             out_led_reg;
  logic [15:0]             in_led_reg;
  logic                    err_led_reg;
  logic [3:0]              cnt_a_reg;
  logic [3:0]              cnt_b_reg;
  logic                    gate3_reg;
  logic                    latch3_reg;
  logic                    hw_event_reg;
  logic                    diag_event_reg;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input pdio_word_type data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // Delay count for one input from its group setting
  function automatic logic [`PDIO_CNT_W-1:0] delay_limit(input pdio_delay_type sel,
                                                         input logic fast);
    logic [`PDIO_CNT_W-1:0] lim;
    lim = LIM_3MS;
    unique case (sel)
      PDIO_DLY_100US: lim = fast ? LIM_100US : LIM_500US;
      PDIO_DLY_500US: lim = LIM_500US;
      PDIO_DLY_3MS:   lim = LIM_3MS;
      PDIO_DLY_15MS:  lim = LIM_15MS;
    endcase
    return lim;
  endfunction : delay_limit

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Write is carried out once address and data are both held
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // Decode of the held write address
  always_comb begin
    unique case (aw_addr_reg)
      `PDIO_ADDR_BYTE_LOW, `PDIO_ADDR_BYTE_HIGH, `PDIO_ADDR_RISE_EN, `PDIO_ADDR_FALL_EN,
      `PDIO_ADDR_DELAY_CFG, `PDIO_ADDR_PENDING, `PDIO_ADDR_DIAG, `PDIO_ADDR_OUT_SEL:
        wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Address and data holding, taken in either order
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      w_full_reg  <= 1'b0;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else if (ce_i) begin
      if (axi_awvalid_i && awready_reg) begin
        aw_addr_reg <= axi_awaddr_i;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (axi_wvalid_i && wready_reg) begin
        w_data_reg <= axi_wdata_i;
        w_strb_reg <= axi_wstrb_i;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && axi_bready_i) begin
        bvalid_reg  <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Read word: input byte in the low lane, output byte read back above it
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (axi_araddr_i)
      `PDIO_ADDR_BYTE_LOW: begin
        rd_word[7:0]  = filt_lvl[7:0];
        rd_word[15:8] = out_low_reg;
      end
      `PDIO_ADDR_BYTE_HIGH: begin
        rd_word[7:0]   = filt_lvl[15:8];
        rd_word[11:8]  = out_high_reg;
      end
      `PDIO_ADDR_RISE_EN:  rd_word[15:0] = rise_en_reg;
      `PDIO_ADDR_FALL_EN:  rd_word[15:0] = fall_en_reg;
      `PDIO_ADDR_DELAY_CFG: begin
        for (int g = 0; g < 4; g++) rd_word[2*g +: 2] = delay_cfg_reg[g];
      end
      `PDIO_ADDR_PENDING:  rd_word[15:0] = pend_reg;
      `PDIO_ADDR_DIAG:     rd_word[`PDIO_DIAG_LOST_BIT] = lost_reg;
      `PDIO_ADDR_OUT_SEL: begin
        for (int k = 0; k < 4; k++) rd_word[2*k +: 2] = out_sel_reg[k];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (ce_i) begin
      if (axi_arvalid_i && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_word;
        rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && axi_rready_i) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  // Output bytes and configuration
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      out_low_reg  <= `PDIO_OUT_LOW_RST;
      out_high_reg <= `PDIO_OUT_HIGH_RST;
      rise_en_reg  <= `PDIO_EDGE_EN_RST;
      fall_en_reg  <= `PDIO_EDGE_EN_RST;
      for (int g = 0; g < 4; g++) begin
        delay_cfg_reg[g] <= pdio_delay_type'(2'(`PDIO_DELAY_CFG_RST >> (2*g)));
        out_sel_reg[g]   <= pdio_src_type'(2'(`PDIO_OUT_SEL_RST >> (2*g)));
      end
    end else if (ce_i && do_write && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        `PDIO_ADDR_BYTE_LOW:  out_low_reg  <= w_data_reg[7:0];
        `PDIO_ADDR_BYTE_HIGH: out_high_reg <= w_data_reg[3:0];
        `PDIO_ADDR_RISE_EN:   rise_en_reg  <= merge16(rise_en_reg, w_data_reg, w_strb_reg);
        `PDIO_ADDR_FALL_EN:   fall_en_reg  <= merge16(fall_en_reg, w_data_reg, w_strb_reg);
        `PDIO_ADDR_DELAY_CFG: begin
          for (int g = 0; g < 4; g++) delay_cfg_reg[g] <= pdio_delay_type'(w_data_reg[2*g +: 2]);
        end
        `PDIO_ADDR_OUT_SEL: begin
          for (int k = 0; k < 4; k++) out_sel_reg[k] <= pdio_src_type'(w_data_reg[2*k +: 2]);
        end
        default: ;
      endcase
    end
  end

  // Upper lane writes of the edge enables without a low lane strobe
  // are folded into the merge above only when lane 0 is strobed, so
  // enables for inputs 8 to 15 need lane 1 together with lane 0.

  // Write-one-to-clear strobes for the pending and lost flags
  always_comb begin
    pend_clr = '0;
    lost_clr = 1'b0;
    if (do_write && aw_addr_reg == `PDIO_ADDR_PENDING)
      pend_clr = merge16(16'h0000, w_data_reg, w_strb_reg);
    if (do_write && aw_addr_reg == `PDIO_ADDR_DIAG && w_strb_reg[0])
      lost_clr = w_data_reg[`PDIO_DIAG_LOST_BIT];
  end

  // --------------------------------------------------------------------------
  // Input filters, one per channel
  // --------------------------------------------------------------------------
  for (genvar ch = 0; ch < 16; ch++) begin : g_filt
    pdio_filt_if ch_if ();

    assign ch_if.raw   = din_i[ch];
    assign ch_if.limit = delay_limit(delay_cfg_reg[ch / `PDIO_GROUP_SIZE],
                                     FAST_MASK[ch]);
    assign filt_lvl[ch] = ch_if.level;

    pdio_in_filter u_filt (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .flt       (ch_if.filt)
    );
  end

  // --------------------------------------------------------------------------
  // Edge events and lost-event diagnostic
  // --------------------------------------------------------------------------
  // Enabled edges of the filtered level
  assign edge_evt = (filt_lvl & ~prev_lvl_reg & rise_en_reg)
                  | (~filt_lvl & prev_lvl_reg & fall_en_reg);

  // Pending flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prev_lvl_reg <= '0;
      pend_reg     <= '0;
      lost_reg     <= 1'b0;
    end else if (ce_i) begin
      prev_lvl_reg <= filt_lvl;
      pend_reg     <= (pend_reg & ~pend_clr) | edge_evt;
      if (|(edge_evt & pend_reg & ~pend_clr))
        lost_reg <= 1'b1;
      else if (lost_clr)
        lost_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Output pins and indicators
  // --------------------------------------------------------------------------
  // Pin sources: pins 0,1 take PWM or counter outputs when selected, pins 2,3 take the counter output for any non-plain choice
  always_comb begin
    dout_next = {out_high_reg, out_low_reg};
    for (int k = 0; k < 2; k++) begin
      unique case (out_sel_reg[k])
        PDIO_SRC_PWM:     dout_next[k] = pwm_i[k];
        PDIO_SRC_COUNTER: dout_next[k] = cnt_out_i[k];
        default:          dout_next[k] = out_low_reg[k];
      endcase
    end
    for (int k = 2; k < 4; k++) begin
      if (out_sel_reg[k] != PDIO_SRC_PLAIN)
        dout_next[k] = cnt_out_i[k];
    end
  end

  // Registered pins, counter feeds and indicators
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dout_reg       <= '0;
      out_led_reg    <= '0;
      in_led_reg     <= '0;
      err_led_reg    <= 1'b0;
      cnt_a_reg      <= '0;
      cnt_b_reg      <= '0;
      gate3_reg      <= 1'b0;
      latch3_reg     <= 1'b0;
      hw_event_reg   <= 1'b0;
      diag_event_reg <= 1'b0;
    end else if (ce_i) begin
      dout_reg       <= dout_next;
      out_led_reg    <= dout_next;
      in_led_reg     <= filt_lvl;
      err_led_reg    <= overload_i;
      cnt_a_reg      <= {filt_lvl[9], filt_lvl[6], filt_lvl[3], filt_lvl[0]};
      cnt_b_reg      <= {filt_lvl[10], filt_lvl[7], filt_lvl[4], filt_lvl[1]};
      gate3_reg      <= filt_lvl[11];
      latch3_reg     <= filt_lvl[15];
      hw_event_reg   <= |pend_reg;
      diag_event_reg <= lost_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Port drive
  // --------------------------------------------------------------------------
  assign axi_awready_o = awready_reg;
  assign axi_wready_o  = wready_reg;
  assign axi_bvalid_o  = bvalid_reg;
  assign axi_bresp_o   = bresp_reg;
  assign axi_arready_o = arready_reg;
  assign axi_rvalid_o  = rvalid_reg;
  assign axi_rdata_o   = rdata_reg;
  assign axi_rresp_o   = rresp_reg;
  assign dout_o        = dout_reg;
  assign out_led_o     = out_led_reg;
  assign in_led_o      = in_led_reg;
  assign err_led_o     = err_led_reg;
  assign cnt_a_o       = cnt_a_reg;
  assign cnt_b_o       = cnt_b_reg;
  assign gate3_o       = gate3_reg;
  assign latch3_o      = latch3_reg;
  assign hw_event_o    = hw_event_reg;
  assign diag_event_o  = diag_event_reg;

endmodule : pdio_port

// file: tb/pdio_monitor.sv
// Pin-level checks of the digital I/O port
`timescale 1ns/1ps
module pdio_monitor (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [15:0] din_i,
  input wire logic        overload_i,
  input wire logic        axi_awready_o,
  input wire logic        axi_wready_o,
  input wire logic        axi_bvalid_o,
  input wire logic        axi_arready_o,
  input wire logic        axi_rvalid_o,
  input wire logic [11:0] dout_o,
  input wire logic [15:0] in_led_o,
  input wire logic [11:0] out_led_o,
  input wire logic        err_led_o,
  input wire logic        hw_event_o,
  input wire logic        diag_event_o,
  input wire logic [3:0]  cnt_a_o,
  input wire logic        gate3_o,
  input wire logic        latch3_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Input tracks, indicators and outputs
  cnt_feed_a: assert property (cnt_a_o == {in_led_o[9], in_led_o[6], in_led_o[3], in_led_o[0]})
    else $error("counter feed wrong");
  gate_latch_a: assert property (gate3_o == in_led_o[11] && latch3_o == in_led_o[15])
    else $error("gate or latch wrong");
  out_led_a: assert property (out_led_o == dout_o) else $error("output led wrong");
  err_led_a: assert property (err_led_o == $past(overload_i)) else $error("error led wrong");
  in_filter_a: assert property ($rose(in_led_o[0]) |-> $past(din_i[0], 2) && $past(din_i[0], 3))
    else $error("filter too quick");
  lost_pend_a: assert property ($rose(diag_event_o) |-> $past(hw_event_o)) else $error("lost without pending");
  dout_write_a: assert property ($changed(dout_o[11:4]) |-> $past(axi_bvalid_o))
    else $error("output moved without write");
  bus_busy_a: assert property ((axi_bvalid_o |-> !axi_awready_o && !axi_wready_o) and
    (axi_rvalid_o |-> !axi_arready_o)) else $error("ready during answer");
  // Main scenarios
  cover property ($rose(diag_event_o));
  cover property ($rose(err_led_o));
  cover property ($rose(hw_event_o));
endmodule : pdio_monitor

// file: tb/pdio_field.sv
// Field side model: sensors on the inputs, loads on the outputs
`timescale 1ns/1ps
module pdio_field (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] level_i,
  input  wire logic [11:0] short_i,
  input  wire logic [11:0] dout_i,
  output logic      [15:0] din_o = 16'h0000,
  output logic             overload_o = 1'b0
);
  // Sensors settle on the clock; a driven shorted load trips overload
  always @(posedge clk_sys_i) begin
    din_o <= level_i;
    overload_o <= |(dout_i & short_i);
  end
endmodule : pdio_field

// file: tb/tb_top.sv
// Self-checking bench of the digital I/O port
`timescale 1ns/1ps
module tb_top;
  import pdio_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, awv = 0, wv = 0, arv = 0, ce = 1, brdy = 0, rrdy = 0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, ovl, g3, l3, hw, dg, err_led;
  logic [11:0] awa = 12'h000, ara = 12'h000, short_m = 12'h000, dout, out_led;
  logic [15:0] level = 16'h0000, din, in_led;
  logic [3:0] cnt_out = 4'h0, ca, cb;
  logic [1:0] pwm = 2'h0, bresp, rresp, r;
  pdio_word_type wda = 32'h0, rdata, d;
  int err_count = 0, checked = 0;
  // Clock
  always #20 clk_sys_i = ~clk_sys_i;
  pdio_port #(.DLY_500US_CYC(20), .DLY_3MS_CYC(40), .DLY_15MS_CYC(80)) uut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce), .axi_awaddr_i(awa), .axi_awvalid_i(awv),
    .axi_awready_o(aw_rdy), .axi_wdata_i(wda), .axi_wstrb_i(4'hF), .axi_wvalid_i(wv), .axi_wready_o(w_rdy),
    .axi_bresp_o(bresp), .axi_bvalid_o(b_vld), .axi_bready_i(brdy), .axi_araddr_i(ara), .axi_arvalid_i(arv),
    .axi_arready_o(ar_rdy), .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(r_vld), .axi_rready_i(rrdy),
    .din_i(din), .dout_o(dout), .overload_i(ovl), .pwm_i(pwm), .cnt_out_i(cnt_out), .cnt_a_o(ca), .cnt_b_o(cb),
    .gate3_o(g3), .latch3_o(l3), .hw_event_o(hw), .diag_event_o(dg), .in_led_o(in_led), .out_led_o(out_led),
    .err_led_o(err_led));
  pdio_field fld (.clk_sys_i(clk_sys_i), .level_i(level), .short_i(short_m), .dout_i(dout), .din_o(din),
    .overload_o(ovl));
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  task ck(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask : ck
  // Write: address and data offered together, each released when taken
  task wr(input logic [11:0] a, input pdio_word_type v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awa <= a;
    wda <= v;
    awv <= 1;
    wv <= 1;
    while (pa || pw) begin
      @(posedge clk_sys_i);
      pa = pa & ~aw_rdy;
      pw = pw & ~w_rdy;
      awv <= pa;
      wv <= pw;
    end
    brdy <= 1;
    do @(posedge clk_sys_i); while (b_vld !== 1'b1);
    r = bresp;
    brdy <= 0;
  endtask : wr
  task rd(input logic [11:0] a);
    ara <= a;
    arv <= 1;
    do @(posedge clk_sys_i); while (ar_rdy !== 1'b1);
    arv <= 0;
    rrdy <= 1;
    do @(posedge clk_sys_i); while (r_vld !== 1'b1);
    d = rdata;
    r = rresp;
    rrdy <= 0;
  endtask : rd
  task t_reset;
    rd(12'h300);
    ck(d, 32'h0);
    rd(12'h304);
    ck(d, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_out;
    wr(12'h220, 32'hA5);
    wr(12'h224, 32'hF3);
    tick(2);
    ck(dout, 12'h3A5);
    rd(12'h224);
    ck(d[15:8], 8'h03);
    wr(12'h3F0, 32'h1);
    ck(r, 2'h2);
    rd(12'h3F0);
    ck(r, 2'h2);
    ck(d, 32'h0);
    cnt_out <= 4'hA;
    wr(12'h314, 32'h89);
    tick(2);
    ck(dout[3:0], 4'hE);
    wr(12'h314, 32'h0);
    short_m <= 12'h001;
    tick(3);
    ck(err_led, 1'b1);
    $display("output test done");
  endtask : t_out
  task t_in;
    short_m <= 12'h000;
    wr(12'h308, 32'h55);
    level <= 16'h8A01;
    tick(4);
    ck(in_led, 16'h0);
    tick(30);
    ck({cb, ca, g3, l3, in_led}, 26'h0278A01);
    rd(12'h220);
    ck(d[7:0], 8'h01);
    rd(12'h224);
    ck(d[7:0], 8'h8A);
    $display("input test done");
  endtask : t_in
  task t_irq;
    level <= 16'h0;
    tick(30);
    wr(12'h300, 32'h1);
    wr(12'h304, 32'h2);
    level <= 16'h2;
    tick(30);
    ck(hw, 1'b0);
    level <= 16'h1;
    tick(30);
    rd(12'h30C);
    ck({dg, d[15:0]}, 17'h3);
    level <= 16'h0;
    tick(30);
    level <= 16'h1;
    tick(30);
    ck(dg, 1'b1);
    wr(12'h30C, 32'h3);
    wr(12'h310, 32'h1);
    tick(3);
    ck({hw, dg}, 2'h0);
    $display("event test done");
  endtask : t_irq
  task t_fast;
    wr(12'h308, 32'h0);
    level <= 16'h7;
    tick(30);
    ck(in_led[2:0], 3'h5);
    tick(2500);
    ck({cb, ca, in_led[2:0]}, 11'h08F);
    $display("delay test done");
  endtask : t_fast
  task t_ce;
    ce <= 0;
    level <= 16'h0;
    tick(40);
    ck(in_led[2:0], 3'h7);
    ce <= 1;
    tick(40);
    ck(in_led[2:0], 3'h3);
    $display("enable test done");
  endtask : t_ce
  task results;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    tick(8);
    reset_i <= 0;
    t_reset;
    t_out;
    t_in;
    t_irq;
    t_fast;
    t_ce;
    results;
  end
  // Watchdog
  initial begin
    #400000;
    err_count++;
    results;
  end
endmodule : tb_top
bind pdio_port pdio_monitor mon (.clk_sys_i, .reset_i, .din_i, .overload_i, .axi_awready_o, .axi_wready_o,
  .axi_bvalid_o, .axi_arready_o, .axi_rvalid_o, .dout_o, .in_led_o, .out_led_o, .err_led_o, .hw_event_o,
  .diag_event_o, .cnt_a_o, .gate3_o, .latch3_o);
